// ### hw/buck_ctrl_defs.vh
// constants for the buck enable and voltage-setting control block
// assumes inclusion by bare name from the hw/ design files
`ifndef BUCK_CTRL_DEFS_VH
`define BUCK_CTRL_DEFS_VH

// register offsets on the serial interface
`define REG_SETTING_ZERO   8'h00
`define REG_SETTING_ONE    8'h01
`define REG_CONTROL        8'h02

// field positions
`define SOFT_ON_BIT        7
`define CODE_HI            6
`define CODE_LO            0
`define DIS_BIT            7
`define SLEW_HI            6
`define SLEW_LO            4
`define RANGE_BIT          3

// reset values: soft flags set so the pin alone runs the buck
`define SETTING_ZERO_RST   8'hb0
`define SETTING_ONE_RST    8'hb0
`define CONTROL_RST        8'hf0

// slew codes 0..7 are dvs rates; soft-start extends down by 2 steps
`define SLEW_SLOWEST       3'h7
`define MIN_CODE           7'h00
`define RANGE_RST          1'b0
// 600 mV expressed in 6.25 mV steps
`define CODE_OFFSET        14'd96

// timing, clk_sys at 40 MHz
`define CLK_MHZ            40
`define HW_DELAY_US        350
`define SW_DELAY_US        315
`define DVS_DELAY_US       3
// cycle counts are us times CLK_MHZ, sized for the 14-bit delay timer
`define HW_DELAY_CYC       14'd14000
`define SW_DELAY_CYC       14'd12600
`define DVS_DELAY_CYC      14'd120
// one lsb of 6.25 mV at 3.125 mV/us is 2 us = 80 cycles, fastest rate
`define STEP_BASE_CYC      16'd80

// power-good thresholds in percent
`define POK_FALL_PCT       7'd88
`define POK_RISE_PCT       7'd92
`define PCT_FULL           7'd100

`endif

// ### hw/slew_tick.v
// slew tick divider: one-cycle enable pulse per dac step
// assumes clk_sys at 40 MHz; period doubles per slower slew code
`timescale 1ns/100ps
`default_nettype none
`include "buck_ctrl_defs.vh"

module slew_tick (
  // clock and reset
  input  wire       clk_sys,
  input  wire       reset,
  // control
  input  wire       run,
  input  wire [2:0] slew,
  input  wire       soft_start,
  // tick out
  output reg        tick
);

  reg  [15:0] cnt_q;
  reg  [15:0] period;

  // soft-start rates run two steps slower than dvs, giving ten rates
  always @* begin
    period = `STEP_BASE_CYC << slew;
    if (soft_start)
      period = period << 2;
  end

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b0;
    end else if (!run) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b0;
    end else if (cnt_q >= period - 16'h0001) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick  <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### hw/delay_timer.v
// one-shot delay timer, done pulses once after load plus count
// count is captured at load and may change while running
`timescale 1ns/100ps
`default_nettype none

module delay_timer (
  // clock and reset
  input  wire        clk_sys,
  input  wire        reset,
  // control
  input  wire        load,
  input  wire        abort,
  input  wire [13:0] count,
  // status
  output reg         busy,
  output reg         done
);

  reg  [13:0] cnt_q;

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_q <= 14'h0000;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
      end else if (load) begin
        cnt_q <= count;
        busy  <= 1'b1;
      end else if (busy) begin
        if (cnt_q <= 14'h0001) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 14'h0001;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ### hw/buck_ctrl.v
// buck enable, setting select, soft-start and dvs slew control
// assumes register port from a serial slave on clk_sys; pins asynchronous
`timescale 1ns/100ps
`default_nettype none
`include "buck_ctrl_defs.vh"

module buck_ctrl (
  // clock and reset
  input  wire       clk_sys,
  input  wire       reset,
  // pins from outside
  input  wire       enable_pin,
  input  wire       setting_select_pin,
  // register port from the serial slave
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  // sensed output, as dac-equivalent code plus the 96-code offset
  input  wire [13:0] vout_sense,
  // analog controls
  output reg  [6:0] dac_code,
  output reg        range_high,
  output reg        switching_on,
  output reg        discharge_on,
  output reg        ramp_active,
  output reg        power_good
);

  localparam [3:0] ST_OFF   = 4'b0001;
  localparam [3:0] ST_DELAY = 4'b0010;
  localparam [3:0] ST_SOFT  = 4'b0100;
  localparam [3:0] ST_RUN   = 4'b1000;

  // setting byte to its seven-bit level code
  function [6:0] code_of;
    input [7:0] setting;
    begin
      code_of = setting[`CODE_HI:`CODE_LO];
    end
  endfunction

  // soft-start and run both switch the power stage
  function is_active;
    input [3:0] st;
    begin
      is_active = (st == ST_SOFT) || (st == ST_RUN);
    end
  endfunction

  // level times a percentage, wide enough that nothing overflows
  function [20:0] scale_pct;
    input [13:0] level;
    input [6:0]  pct;
    begin
      scale_pct = level * pct;
    end
  endfunction

  // one lsb toward the target, holding once equal
  function [6:0] step_toward;
    input [6:0] cur;
    input [6:0] tgt;
    begin
      if (cur < tgt)
        step_toward = cur + 7'h01;
      else if (cur > tgt)
        step_toward = cur - 7'h01;
      else
        step_toward = cur;
    end
  endfunction

  reg  [7:0]  setting_zero_q;
  reg  [7:0]  setting_one_q;
  reg  [7:0]  control_q;
  reg  [1:0]  en_sync_q;
  reg  [1:0]  sel_sync_q;
  reg         en_prev_q;
  reg         sel_prev_q;
  reg         flag_prev_q;
  reg  [3:0]  state_q;
  reg  [3:0]  state_d;
  reg         dvs_wait_q;
  reg  [6:0]  target;
  reg         soft_on_flag_selected;
  wire        run_ok;
  wire        en_s;
  wire        sel_s;
  wire        tick;
  wire        tmr_busy;
  wire        tmr_done;
  reg         tmr_load;
  reg  [13:0] tmr_count;
  reg  [13:0] set_x100;
  wire        sel_edge;

  // only the second flop is read downstream
  assign en_s  = en_sync_q[1];
  assign sel_s = sel_sync_q[1];
  // select pin moved since last cycle, already synchronised
  assign sel_edge = (sel_s != sel_prev_q);

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      en_sync_q  <= 2'b00;
      sel_sync_q <= 2'b00;
    end else begin
      en_sync_q  <= {en_sync_q[0], enable_pin};
      sel_sync_q <= {sel_sync_q[0], setting_select_pin};
    end
  end

  // select pin chooses flag and code
  always @* begin
    if (sel_s) begin
      soft_on_flag_selected = setting_one_q[`SOFT_ON_BIT];
      target = code_of(setting_one_q);
    end else begin
      soft_on_flag_selected = setting_zero_q[`SOFT_ON_BIT];
      target = code_of(setting_zero_q);
    end
  end

  assign run_ok = en_s & soft_on_flag_selected;

  // registers only reset by reset, never by enable state
  // writes accepted whatever the pin level
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      setting_zero_q <= `SETTING_ZERO_RST;
      setting_one_q  <= `SETTING_ONE_RST;
      control_q      <= `CONTROL_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `REG_SETTING_ZERO: setting_zero_q <= reg_wdata;
        `REG_SETTING_ONE:  setting_one_q  <= reg_wdata;
        `REG_CONTROL:      control_q      <= reg_wdata;
        // unmapped addresses leave every register as it was
        default:           setting_zero_q <= setting_zero_q;
      endcase
    end
  end

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `REG_SETTING_ZERO: reg_rdata <= setting_zero_q;
        `REG_SETTING_ONE:  reg_rdata <= setting_one_q;
        `REG_CONTROL:      reg_rdata <= control_q;
        // unmapped reads return zero, so probing is harmless
        default:           reg_rdata <= 8'h00;
      endcase
    end
  end

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      // idle pin levels, so no false edge follows reset
      en_prev_q   <= 1'b0;
      sel_prev_q  <= 1'b0;
      flag_prev_q <= 1'b0;
    end else begin
      en_prev_q   <= en_s;
      sel_prev_q  <= sel_s;
      flag_prev_q <= soft_on_flag_selected;
    end
  end

  // one timer serves both start delays and the dvs delay
  // pin edge wins the longer delay when both rise together
  always @* begin
    tmr_load  = 1'b0;
    tmr_count = `DVS_DELAY_CYC;
    if (state_q == ST_OFF && run_ok) begin
      tmr_load = 1'b1;
      if (en_s && !en_prev_q)
        tmr_count = `HW_DELAY_CYC;
      else
        tmr_count = `SW_DELAY_CYC;
    end else if (state_q == ST_RUN && sel_edge) begin
      tmr_load  = 1'b1;
      tmr_count = `DVS_DELAY_CYC;
    end
  end

  // off, delay, soft-start, run; losing run_ok drops straight to off
  always @* begin
    case (state_q)
      ST_OFF:   state_d = run_ok ? ST_DELAY : ST_OFF;
      ST_DELAY: state_d = !run_ok ? ST_OFF :
                          (tmr_done ? ST_SOFT : ST_DELAY);
      ST_SOFT:  state_d = !run_ok ? ST_OFF :
                          (dac_code == target ? ST_RUN : ST_SOFT);
      ST_RUN:   state_d = run_ok ? ST_RUN : ST_OFF;
      default:  state_d = ST_OFF;
    endcase
  end

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_q    <= ST_OFF;
      dvs_wait_q <= 1'b0;
    end else begin
      state_q <= state_d;
      // toggle holds dvs stepping until the delay ends
      if (state_q == ST_RUN && sel_edge)
        dvs_wait_q <= 1'b1;
      else if (tmr_done || state_q != ST_RUN)
        dvs_wait_q <= 1'b0;
    end
  end

  delay_timer u_delay (
    .clk_sys (clk_sys),
    .reset   (reset),
    .load    (tmr_load),
    .abort   (!run_ok),
    .count   (tmr_count),
    .busy    (tmr_busy),
    .done    (tmr_done)
  );

  // divider restarts per ramp, since it runs only while steps are owed
  slew_tick u_tick (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .run        ((state_q == ST_SOFT) ||
                 (state_q == ST_RUN && !dvs_wait_q && dac_code != target)),
    .slew       (control_q[`SLEW_HI:`SLEW_LO]),
    .soft_start (state_q == ST_SOFT),
    .tick       (tick)
  );

  // up/down counter, one lsb per tick toward target
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dac_code <= `MIN_CODE;
    end else if (state_q == ST_OFF || state_q == ST_DELAY) begin
      dac_code <= `MIN_CODE;
    end else if (tick) begin
      dac_code <= step_toward(dac_code, target);
    end
  end

  // range only follows the bit while off, so a ramp never crosses
  // limitation: a range write while running waits for the next off
  always @(posedge clk_sys or posedge reset) begin
    if (reset)
      range_high <= `RANGE_RST;
    else if (state_q == ST_OFF)
      range_high <= control_q[`RANGE_BIT];
  end

  // commanded level in 6.25 mV units, offset 96 codes is 600 mV
  // the high-range gain scales both sides, so it drops out here
  always @* begin
    set_x100 = `CODE_OFFSET + {7'h00, dac_code};
  end

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      switching_on <= 1'b0;
      discharge_on <= 1'b0;
      ramp_active  <= 1'b0;
      power_good   <= 1'b0;
    end else begin
      switching_on <= is_active(state_q);
      // wait for off so discharge never overlaps switching
      discharge_on <= control_q[`DIS_BIT] & ~run_ok & (state_q == ST_OFF);
      ramp_active  <= (state_q == ST_SOFT) || (dac_code != target &&
                      state_q == ST_RUN);
      // compare sensed and set levels in the same units
      if (state_q != ST_RUN)
        power_good <= 1'b0;
      else if (scale_pct(vout_sense, `PCT_FULL) <
               scale_pct(set_x100, `POK_FALL_PCT))
        power_good <= 1'b0;
      else if (scale_pct(vout_sense, `PCT_FULL) >
               scale_pct(set_x100, `POK_RISE_PCT))
        power_good <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// ### bench/output_model.sv
// behavioural output stage beside the buck control block
// assumes dac_code and switching_on straight from buck_ctrl
`timescale 1ns/100ps
`default_nettype none
module output_model (
  // clock
  input  wire logic        clk_sys,
  // from the regulator
  input  wire logic [6:0]  dac_code,
  input  wire logic        switching_on,
  // test control
  input  wire logic        sag,
  // sensed output
  output var  logic [13:0] vout_sense
);
  initial vout_sense = 14'h0000;
  // sag stands for a load dump pulling the output to ground
  always @(posedge clk_sys) begin
    if (switching_on && !sag) begin
      vout_sense <= {7'h00, dac_code} + 14'd96;
    end else begin
      vout_sense <= 14'h0000;
    end
  end
endmodule
`default_nettype wire

// ### bench/buck_ctrl_chk.sv
// port checker for the buck control block
// assumes one clk_sys domain, bound onto buck_ctrl below
`timescale 1ns/100ps
`default_nettype none
module buck_ctrl_chk (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // pins
  input  wire logic       enable_pin,
  input  wire logic       setting_select_pin,
  // analog controls
  input  wire logic [6:0] dac_code,
  input  wire logic       range_high,
  input  wire logic       switching_on,
  input  wire logic       discharge_on,
  input  wire logic       ramp_active,
  input  wire logic       power_good
);
  logic [13:0] on_cnt_q;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  // saturating count of cycles with the pin high
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      on_cnt_q <= 14'h0000;
    end else if (!enable_pin) begin
      on_cnt_q <= 14'h0000;
    end else if (on_cnt_q != 14'h3fff) begin
      on_cnt_q <= on_cnt_q + 14'h0001;
    end
  end

  off_no_good_a: assert property (
    !switching_on |-> !power_good) else $error("power good while off");
  on_no_dis_a: assert property (
    switching_on |-> !discharge_on) else $error("discharge while on");
  pin_low_off_a: assert property (
    !enable_pin [*5] |-> !switching_on) else $error("running, pin low");
  single_step_a: assert property (
    switching_on && $past(switching_on) && $changed(dac_code) |->
    dac_code == $past(dac_code) + 7'h01 ||
    dac_code == $past(dac_code) - 7'h01) else $error("dac jumped");
  step_gap_a: assert property (
    switching_on && $past(switching_on) && $changed(dac_code) |=>
    $stable(dac_code) [*8]) else $error("dac steps too close");
  ramp_flag_a: assert property (
    switching_on && $past(switching_on) && $changed(dac_code) |->
    $past(ramp_active)) else $error("dac moved without ramp flag");
  start_delay_a: assert property (
    $rose(switching_on) |-> on_cnt_q >= 14'd12600)
    else $error("start before delay");
  range_hold_a: assert property (
    switching_on && $past(switching_on) |-> $stable(range_high))
    else $error("range changed while running");

  cover property ($rose(switching_on));
  cover property ($changed(dac_code) && setting_select_pin);
  cover property ($rose(discharge_on));
endmodule

bind buck_ctrl buck_ctrl_chk buck_ctrl_chk_inst (.clk_sys, .reset,
  .enable_pin, .setting_select_pin, .dac_code, .range_high,
  .switching_on, .discharge_on, .ramp_active, .power_good);
`default_nettype wire

// ### bench/buck_ctrl_tb.sv
// testbench for the buck control block
// assumes buck_ctrl at 40 MHz with the checker bound in
`timescale 1ns/100ps
`default_nettype none
module buck_ctrl_tb;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        enable_pin = 1'b0;
  logic        setting_select_pin = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        sag = 1'b0;
  logic [7:0]  reg_rdata;
  logic [13:0] vout_sense;
  logic [6:0]  dac_code;
  logic        range_high;
  logic        switching_on;
  logic        discharge_on;
  logic        ramp_active;
  logic        power_good;
  int          bad_count = 0;
  int          n_tests = 0;

  always #12.5 clk_sys = ~clk_sys;

  buck_ctrl buck_ctrl_inst (.clk_sys, .reset, .enable_pin,
    .setting_select_pin, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .vout_sense, .dac_code, .range_high, .switching_on,
    .discharge_on, .ramp_active, .power_good);
  output_model output_model_inst (.clk_sys, .dac_code, .switching_on,
    .sag, .vout_sense);

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    #1 chk(reg_rdata, exp);
  endtask
  // checks both that the change came and that it did not come early
  task wait_sw(input logic v, input int lo, input int hi);
    int n;
    n = 0;
    while (switching_on !== v && n < hi) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk({6'h00, n >= lo, switching_on}, {6'h00, 1'b1, v});
  endtask
  task wait_dac(input logic [6:0] t, input int max);
    int n;
    n = 0;
    while (dac_code !== t && n < max) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk({1'b0, dac_code}, {1'b0, t});
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (50000) @(posedge clk_sys);
    bad_count++;
    stop_test;
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    rd(8'h00, 8'hb0);
    rd(8'h01, 8'hb0);
    rd(8'h02, 8'hf0);
    rd(8'h05, 8'h00);
    chk({7'h00, discharge_on}, 8'h01);
    $display("test reset values done");
    wr(8'h02, 8'h88);
    repeat (3) @(posedge clk_sys);
    #1 chk({7'h00, range_high}, 8'h01);
    // fastest slew keeps the soft-start within the run budget
    wr(8'h02, 8'h80);
    wr(8'h07, 8'h55);
    wr(8'h00, 8'h84);
    wr(8'h01, 8'h86);
    rd(8'h02, 8'h80);
    rd(8'h00, 8'h84);
    chk({7'h00, range_high}, 8'h00);
    $display("test register setup done");
    @(posedge clk_sys);
    enable_pin <= 1'b1;
    wait_sw(1'b1, 13990, 14100);
    wait_dac(7'h04, 3000);
    chk({7'h00, discharge_on}, 8'h00);
    wr(8'h02, 8'h88);
    repeat (3) @(posedge clk_sys);
    #1 chk({7'h00, range_high}, 8'h00);
    wr(8'h02, 8'h80);
    $display("test pin enable done");
    @(posedge clk_sys);
    setting_select_pin <= 1'b1;
    repeat (5) @(posedge clk_sys);
    #1 chk({7'h00, ramp_active}, 8'h01);
    wait_dac(7'h06, 400);
    @(posedge clk_sys);
    setting_select_pin <= 1'b0;
    wait_dac(7'h04, 400);
    wr(8'h00, 8'h82);
    wait_dac(7'h02, 250);
    repeat (2) @(posedge clk_sys);
    #1 chk({7'h00, power_good}, 8'h01);
    chk({7'h00, ramp_active}, 8'h00);
    $display("test dvs done");
    @(posedge clk_sys);
    sag <= 1'b1;
    repeat (5) @(posedge clk_sys);
    #1 chk({7'h00, power_good}, 8'h00);
    @(posedge clk_sys);
    sag <= 1'b0;
    wr(8'h00, 8'h02);
    wait_sw(1'b0, 0, 10);
    repeat (2) @(posedge clk_sys);
    #1 chk({7'h00, discharge_on}, 8'h01);
    rd(8'h00, 8'h02);
    wr(8'h00, 8'h82);
    wait_sw(1'b1, 12580, 12700);
    $display("test soft enable done");
    @(posedge clk_sys);
    enable_pin <= 1'b0;
    wait_sw(1'b0, 0, 10);
    rd(8'h01, 8'h86);
    $display("test shutdown done");
    stop_test;
  end
endmodule
`default_nettype wire
